/* hw/sfseq_defines.svh */
// timing constants and cycle counts for the supply fault sequencer
`ifndef SFSEQ_DEFINES_SVH
`define SFSEQ_DEFINES_SVH
`define SFSEQ_CLK_MHZ 100
`define SFSEQ_SS_UP_US 1400
`define SFSEQ_SS_DN_US 2800
`define SFSEQ_TERM_RAMP_US 160
`define SFSEQ_UV_PERSIST_US 200
`define SFSEQ_TERM_PERSIST_US 5000
`define SFSEQ_SS_UP_CYC (`SFSEQ_SS_UP_US * `SFSEQ_CLK_MHZ)
`define SFSEQ_SS_DN_CYC (`SFSEQ_SS_DN_US * `SFSEQ_CLK_MHZ)
`define SFSEQ_TERM_RAMP_CYC (`SFSEQ_TERM_RAMP_US * `SFSEQ_CLK_MHZ)
`define SFSEQ_UV_PERSIST_CYC (`SFSEQ_UV_PERSIST_US * `SFSEQ_CLK_MHZ)
`define SFSEQ_TERM_PERSIST_CYC (`SFSEQ_TERM_PERSIST_US * `SFSEQ_CLK_MHZ)
`define SFSEQ_CNT_W 20
`define SFSEQ_RAMP_W 8
`define SFSEQ_RAMP_FULL 8'hFF
`define SFSEQ_RAMP_STEPS 255
`endif

/* hw/sfseq_persist.sv */
// counts how long a condition holds; restarts whenever it clears
`include "sfseq_defines.svh"
module sfseq_persist #(
  parameter int LIMIT = 20000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // condition and verdict
  input wire logic cond,
  output logic expired
);
  typedef struct packed {
    logic [`SFSEQ_CNT_W-1:0] count;
    logic expired;
  } sfseq_persist_state_t;

  localparam logic [`SFSEQ_CNT_W-1:0] LIM = LIMIT[`SFSEQ_CNT_W-1:0];

  sfseq_persist_state_t st;
  sfseq_persist_state_t next_st;

  always_comb begin
    next_st = st;
    if (!cond) begin
      next_st.count = '0;
      next_st.expired = 1'b0;
    end else if (st.count < LIM) begin
      next_st.count = st.count + `SFSEQ_CNT_W'(1);
    end else begin
      next_st.expired = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired = st.expired;

  property p_expire_needs_cond;
    @(posedge core_clk) disable iff (!rst_n) !cond |=> !expired;
  endproperty
  a_expire_needs_cond: assert property (p_expire_needs_cond) else $error("persistence verdict survived a clear");
endmodule // sfseq_persist

/* hw/sfseq_pkg.sv */
// types shared by the supply fault sequencer
package sfseq_pkg;
  typedef enum logic [2:0] {
    SFSEQ_OFF = 3'h0,
    SFSEQ_REF_WAIT = 3'h1,
    SFSEQ_SOFT_START = 3'h2,
    SFSEQ_RUN = 3'h3,
    SFSEQ_SOFT_STOP = 3'h4,
    SFSEQ_OV_LATCH = 3'h5,
    SFSEQ_HARD_OFF = 3'h6
  } sfseq_state_t;

  // synchronised analog comparator results and control pins
  typedef struct packed {
    logic supply_above_por;
    logic supply_above_uvlo;
    logic shutdown_n;
    logic overvolt_protect;
    logic standby_n;
    logic pulse_skip_n;
    logic smps_over;
    logic smps_under;
    logic term_in_window;
    logic thermal_fault;
    logic ref_valid;
  } sfseq_in_t;

  // drive-side outputs
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
    logic converter_enable;
    logic force_pulse_skip;
    logic forced_pwm;
    logic standby_active;
    logic term_enable;
    logic ref_enable;
    logic internal_ref_enable;
    logic discharge_enable;
  } sfseq_drv_t;
endpackage

/* hw/sfseq_sync.sv */
// two-flop synchroniser for a vector of level inputs
module sfseq_sync #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sfseq_sync_state_t;

  sfseq_sync_state_t st;
  sfseq_sync_state_t next_st;

  always_comb begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;
endmodule // sfseq_sync

/* hw/sfseq_top.sv */
// supply sequencing and fault supervision for a memory power controller
// Overview of operation
// - smps_ok_flag held low in shutdown, soft-start and soft-shutdown.
// - after soft-start, smps_ok_flag released only inside the 85-115% window.
// - converter fault drops both flags and latches off until toggle or supply loss.
// - overvoltage pulls smps_ok_flag low regardless of protection select.
// - term_ok_flag held low in standby, shutdown and soft-start.
// - term_ok_flag released only while termination rail within 10% window.
// - term_ok_flag low for 5ms latches off via soft-shutdown.
// - power-on reset clears latch and state, low gate low, discharge if protected.
// - no switching below lockout; above it converter enabled and soft-start begins.
// - lockout fall kills gates, flags and rails; discharge only if protected.
// - shutdown_n_input rising starts 1.4ms soft-start ramp from zero.
// - pulse-skip forced during startup; mode selects act only afterwards.
// - termination current limit ramps from zero, full at regulation or 160us.
// - reference rail enabled without soft-start ramp.
// - soft-shutdown on shutdown low, 200us undervoltage or 5ms term fault.
// - soft-shutdown ramps target to zero in 2.8ms, then low gate low.
// - protected: discharge stays on after shutdown until next rising shutdown_n_input.
// - protected overvoltage latches low gate high, high gate low, rails off, discharge.
// - unprotected overvoltage only pulls smps_ok_flag low, no latch.
// - fault soft-shutdown keeps high gate off; reference follows converter ramp.
// - thermal fault kills gates, flags, rails immediately without discharge.
// - lockout rise with shutdown high enables internal reference, waits for valid.
// - standby disables termination rail, keeps reference, overrides pulse-skip.
`include "sfseq_defines.svh"
module sfseq_top #(
  parameter int SS_UP_CYC = `SFSEQ_SS_UP_CYC,
  parameter int SS_DN_CYC = `SFSEQ_SS_DN_CYC,
  parameter int TERM_RAMP_CYC = `SFSEQ_TERM_RAMP_CYC,
  parameter int UV_PERSIST_CYC = `SFSEQ_UV_PERSIST_CYC,
  parameter int TERM_PERSIST_CYC = `SFSEQ_TERM_PERSIST_CYC
) (
  // clock and reset (reset stands for the supply power-on reset)
  input wire logic core_clk,
  input wire logic rst_n,
  // comparators and control pins, raw
  input wire sfseq_pkg::sfseq_in_t pins_in,
  // gate drive, rail and discharge controls
  output sfseq_pkg::sfseq_drv_t drive,
  // converter target ramp, 0 to full
  output logic [`SFSEQ_RAMP_W-1:0] target_level,
  // termination current limit ramp, 0 to full
  output logic [`SFSEQ_RAMP_W-1:0] term_limit_level,
  // open-drain power-good flags: pulled low while oe high
  output logic smps_ok_flag_out,
  output logic smps_ok_flag_oe,
  output logic term_ok_flag_out,
  output logic term_ok_flag_oe,
  // latched fault indication
  output logic fault_latched
);
  typedef struct packed {
    sfseq_pkg::sfseq_state_t fsm;
    logic [`SFSEQ_CNT_W-1:0] tmr;
    logic [`SFSEQ_CNT_W-1:0] term_tmr;
    logic [`SFSEQ_RAMP_W-1:0] target;
    logic [`SFSEQ_RAMP_W-1:0] term_lim;
    logic latch;
    logic fault_stop;
    logic shutdown_n_input_prev;
    logic uvlo_prev;
    logic por_prev;
    logic discharge;
    logic smps_low;
    logic term_low;
    sfseq_pkg::sfseq_drv_t drv;
  } sfseq_top_state_t;

  localparam logic [`SFSEQ_CNT_W-1:0] UP_STEP = `SFSEQ_CNT_W'(SS_UP_CYC / `SFSEQ_RAMP_STEPS);
  localparam logic [`SFSEQ_CNT_W-1:0] DN_STEP = `SFSEQ_CNT_W'(SS_DN_CYC / `SFSEQ_RAMP_STEPS);
  localparam logic [`SFSEQ_CNT_W-1:0] TR_STEP = `SFSEQ_CNT_W'(TERM_RAMP_CYC / `SFSEQ_RAMP_STEPS);

  sfseq_pkg::sfseq_in_t in;
  sfseq_top_state_t st;
  sfseq_top_state_t next_st;
  logic uv_expired;
  logic term_expired;

  // raw comparators are asynchronous to core_clk
  sfseq_sync #(.WIDTH($bits(sfseq_pkg::sfseq_in_t))) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_in),
    .sync_out(in)
  );

  sfseq_persist #(.LIMIT(UV_PERSIST_CYC)) u_uv_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cond(in.smps_under && st.fsm == sfseq_pkg::SFSEQ_RUN),
    .expired(uv_expired)
  );

  sfseq_persist #(.LIMIT(TERM_PERSIST_CYC)) u_term_persist (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cond(st.term_low && st.fsm == sfseq_pkg::SFSEQ_RUN),
    .expired(term_expired)
  );

  // advance a ramp counter by one step every step_cyc cycles
  function automatic logic step_due(input logic [`SFSEQ_CNT_W-1:0] t, input logic [`SFSEQ_CNT_W-1:0] step);
    step_due = (t + `SFSEQ_CNT_W'(1) >= step);
  endfunction

  always_comb begin
    next_st = st;
    next_st.shutdown_n_input_prev = in.shutdown_n;
    next_st.uvlo_prev = in.supply_above_uvlo;
    next_st.por_prev = in.supply_above_por;
    next_st.drv.internal_ref_enable = 1'b0;
    next_st.drv.force_pulse_skip = 1'b0;
    next_st.drv.forced_pwm = 1'b0;
    next_st.drv.standby_active = 1'b0;

    // latch clears on shutdown_n toggle, before any new fault is judged
    if (in.shutdown_n && !st.shutdown_n_input_prev) begin
      next_st.latch = 1'b0;
      next_st.discharge = 1'b0;
    end
    // supply coming up wins over a toggle seen in the same cycle
    if (in.supply_above_por && !st.por_prev) begin
      next_st.discharge = in.overvolt_protect;
    end

    case (st.fsm)
      sfseq_pkg::SFSEQ_OFF: begin
        next_st.target = '0;
        next_st.drv = '0;
        next_st.drv.discharge_enable = st.discharge;
        if (in.supply_above_uvlo && in.shutdown_n && !next_st.latch) begin
          next_st.fsm = sfseq_pkg::SFSEQ_REF_WAIT;
        end
      end
      sfseq_pkg::SFSEQ_REF_WAIT: begin
        next_st.drv.internal_ref_enable = 1'b1;
        next_st.drv.low_side_gate = 1'b0;
        next_st.drv.discharge_enable = 1'b0;
        if (in.ref_valid) begin
          next_st.fsm = sfseq_pkg::SFSEQ_SOFT_START;
          next_st.tmr = '0;
          next_st.term_lim = '0;
          next_st.term_tmr = '0;
        end
      end
      sfseq_pkg::SFSEQ_SOFT_START: begin
        next_st.drv.internal_ref_enable = 1'b1;
        next_st.drv.converter_enable = 1'b1;
        next_st.drv.high_side_gate = 1'b1;
        next_st.drv.low_side_gate = 1'b1;
        next_st.drv.force_pulse_skip = 1'b1;
        next_st.drv.ref_enable = 1'b1;
        next_st.tmr = st.tmr + `SFSEQ_CNT_W'(1);
        if (step_due(st.tmr, UP_STEP)) begin
          next_st.tmr = '0;
          if (st.target == `SFSEQ_RAMP_FULL) begin
            next_st.fsm = sfseq_pkg::SFSEQ_RUN;
          end else begin
            next_st.target = st.target + `SFSEQ_RAMP_W'(1);
          end
        end
      end
      sfseq_pkg::SFSEQ_RUN: begin
        next_st.drv.internal_ref_enable = 1'b1;
        next_st.drv.force_pulse_skip = !in.standby_n || in.pulse_skip_n;
        next_st.drv.forced_pwm = in.standby_n && !in.pulse_skip_n;
        next_st.drv.standby_active = !in.standby_n;
        next_st.drv.term_enable = in.standby_n;
        next_st.drv.ref_enable = 1'b1;
        if (!in.standby_n) begin
          next_st.term_lim = '0;
          next_st.term_tmr = '0;
        end else if (in.term_in_window) begin
          next_st.term_lim = `SFSEQ_RAMP_FULL;
        end else if (st.term_lim != `SFSEQ_RAMP_FULL) begin
          next_st.term_tmr = st.term_tmr + `SFSEQ_CNT_W'(1);
          if (step_due(st.term_tmr, TR_STEP)) begin
            next_st.term_tmr = '0;
            next_st.term_lim = st.term_lim + `SFSEQ_RAMP_W'(1);
          end
        end
        if (in.smps_over && in.overvolt_protect) begin
          next_st.fsm = sfseq_pkg::SFSEQ_OV_LATCH;
          next_st.latch = 1'b1;
          next_st.drv = '0;
          next_st.drv.low_side_gate = 1'b1;
          next_st.drv.discharge_enable = 1'b1;
        end else if (!in.shutdown_n || uv_expired || term_expired) begin
          next_st.fsm = sfseq_pkg::SFSEQ_SOFT_STOP;
          next_st.fault_stop = uv_expired || term_expired;
          next_st.latch = st.latch || uv_expired || term_expired;
          next_st.tmr = '0;
        end
      end
      sfseq_pkg::SFSEQ_SOFT_STOP: begin
        next_st.drv.forced_pwm = 1'b1;
        next_st.drv.term_enable = 1'b0;
        next_st.drv.ref_enable = 1'b1;
        next_st.drv.high_side_gate = !st.fault_stop;
        next_st.tmr = st.tmr + `SFSEQ_CNT_W'(1);
        if (step_due(st.tmr, DN_STEP)) begin
          next_st.tmr = '0;
          if (st.target == '0) begin
            next_st.fsm = sfseq_pkg::SFSEQ_OFF;
            next_st.drv = '0;
            next_st.discharge = in.overvolt_protect;
            next_st.fault_stop = 1'b0;
          end else begin
            next_st.target = st.target - `SFSEQ_RAMP_W'(1);
          end
        end
      end
      sfseq_pkg::SFSEQ_OV_LATCH: begin
        next_st.drv = '0;
        next_st.drv.low_side_gate = 1'b1;
        next_st.drv.discharge_enable = 1'b1;
        next_st.discharge = 1'b1;
        if (!next_st.latch) begin
          next_st.fsm = sfseq_pkg::SFSEQ_OFF;
        end
      end
      sfseq_pkg::SFSEQ_HARD_OFF: begin
        next_st.drv = '0;
        next_st.drv.discharge_enable = st.discharge;
        next_st.target = '0;
        if (!next_st.latch || in.supply_above_uvlo) begin
          next_st.fsm = sfseq_pkg::SFSEQ_OFF;
        end
      end
      default: begin
        next_st.fsm = sfseq_pkg::SFSEQ_OFF;
      end
    endcase

    // immediate kills take priority over any sequence step
    if (in.thermal_fault && st.fsm != sfseq_pkg::SFSEQ_OFF) begin
      next_st.fsm = sfseq_pkg::SFSEQ_HARD_OFF;
      next_st.latch = 1'b1;
      next_st.drv = '0;
      next_st.discharge = 1'b0;
    end
    if (!in.supply_above_uvlo && st.uvlo_prev) begin
      next_st.fsm = sfseq_pkg::SFSEQ_HARD_OFF;
      next_st.drv = '0;
      next_st.drv.discharge_enable = in.overvolt_protect;
      next_st.discharge = in.overvolt_protect;
    end

    // window comparators feed the flags; overvoltage always pulls smps low
    next_st.smps_low = (next_st.fsm != sfseq_pkg::SFSEQ_RUN) || in.smps_over || in.smps_under
                       || next_st.latch;
    next_st.term_low = (next_st.fsm != sfseq_pkg::SFSEQ_RUN) || !in.standby_n
                       || !in.term_in_window || next_st.latch;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.fsm <= sfseq_pkg::SFSEQ_OFF;
      st.smps_low <= 1'b1;
      st.term_low <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // protection select is unknown under reset; discharge follows it at release
  always_comb begin
    drive = st.drv;
    if (!rst_n) begin
      drive = '0;
    end
  end

  assign target_level = st.target;
  assign term_limit_level = st.term_lim;
  assign smps_ok_flag_out = 1'b0;
  assign smps_ok_flag_oe = st.smps_low;
  assign term_ok_flag_out = 1'b0;
  assign term_ok_flag_oe = st.term_low;
  assign fault_latched = st.latch;

  sequence s_soft_stop;
    st.fsm == sfseq_pkg::SFSEQ_SOFT_STOP;
  endsequence

  property p_flag_low_outside_run;
    @(posedge core_clk) disable iff (!rst_n) st.fsm != sfseq_pkg::SFSEQ_RUN |-> smps_ok_flag_oe && term_ok_flag_oe;
  endproperty
  a_flag_low_outside_run: assert property (p_flag_low_outside_run) else $error("flag released outside run");

  property p_ov_pulls_flag;
    @(posedge core_clk) disable iff (!rst_n) in.smps_over |=> smps_ok_flag_oe;
  endproperty
  a_ov_pulls_flag: assert property (p_ov_pulls_flag) else $error("overvoltage left smps flag released");

  property p_latch_flags;
    @(posedge core_clk) disable iff (!rst_n) fault_latched |-> smps_ok_flag_oe && term_ok_flag_oe;
  endproperty
  a_latch_flags: assert property (p_latch_flags) else $error("flag released while latched");

  property p_ovp_latch;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_RUN && in.smps_over && in.overvolt_protect && !in.thermal_fault
      && !(st.uvlo_prev && !in.supply_above_uvlo) |=> drive.low_side_gate && !drive.high_side_gate
      && drive.discharge_enable && !drive.term_enable && !drive.ref_enable;
  endproperty
  a_ovp_latch: assert property (p_ovp_latch) else $error("protected overvoltage did not latch gates");

  property p_unprot_ov_runs;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_RUN && in.smps_over && !in.overvolt_protect && in.shutdown_n && !uv_expired
      && !term_expired && !in.thermal_fault && in.supply_above_uvlo |=> st.fsm == sfseq_pkg::SFSEQ_RUN && !fault_latched;
  endproperty
  a_unprot_ov_runs: assert property (p_unprot_ov_runs) else $error("unprotected overvoltage stopped run");

  property p_thermal_off;
    @(posedge core_clk) disable iff (!rst_n)
      in.thermal_fault && st.fsm != sfseq_pkg::SFSEQ_OFF |=> !drive.high_side_gate && !drive.low_side_gate
      && !drive.discharge_enable && !drive.term_enable && !drive.ref_enable;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("thermal fault left outputs on");

  property p_fault_stop_hs_off;
    @(posedge core_clk) disable iff (!rst_n) s_soft_stop ##1 (s_soft_stop and st.fault_stop) |-> !drive.high_side_gate;
  endproperty
  a_fault_stop_hs_off: assert property (p_fault_stop_hs_off) else $error("high gate on in fault soft stop");

  property p_start_pulse_skip;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_SOFT_START ##1 st.fsm == sfseq_pkg::SFSEQ_SOFT_START |-> drive.force_pulse_skip;
  endproperty
  a_start_pulse_skip: assert property (p_start_pulse_skip) else $error("startup not in pulse skip");

  property p_standby_term_off;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_RUN && $past(st.fsm) == sfseq_pkg::SFSEQ_RUN && !$past(in.standby_n)
      |-> !drive.term_enable && drive.ref_enable;
  endproperty
  a_standby_term_off: assert property (p_standby_term_off) else $error("standby left termination on");

  sequence s_leave_soft_stop;
    s_soft_stop ##1 st.fsm == sfseq_pkg::SFSEQ_OFF;
  endsequence

  property p_ramp_end_low_gate;
    @(posedge core_clk) disable iff (!rst_n)
      s_leave_soft_stop |-> !drive.low_side_gate && !drive.high_side_gate && target_level == '0;
  endproperty
  a_ramp_end_low_gate: assert property (p_ramp_end_low_gate) else $error("gate on after soft stop");

  property p_ref_wait_gate;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_REF_WAIT && !in.thermal_fault && in.supply_above_uvlo
      |=> drive.internal_ref_enable && !drive.low_side_gate && !drive.high_side_gate;
  endproperty
  a_ref_wait_gate: assert property (p_ref_wait_gate) else $error("reference wait outputs wrong");

  property p_start_from_zero;
    @(posedge core_clk) disable iff (!rst_n)
      st.fsm == sfseq_pkg::SFSEQ_REF_WAIT ##1 st.fsm == sfseq_pkg::SFSEQ_SOFT_START |-> target_level == '0;
  endproperty
  a_start_from_zero: assert property (p_start_from_zero) else $error("soft start not from zero");
endmodule // sfseq_top

/* sim/sfseq_sys_model.sv */
// system side of the power-good flags: pull-ups on both open-drain lines
module sfseq_sys_model (
  // open-drain flag pins
  input wire logic smps_ok_flag_out,
  input wire logic smps_ok_flag_oe,
  input wire logic term_ok_flag_out,
  input wire logic term_ok_flag_oe,
  // levels the system reads
  output logic smps_ok,
  output logic term_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line floats up through the external pull-up
  assign smps_ok = smps_ok_flag_oe ? smps_ok_flag_out : 1'b1;
  assign term_ok = term_ok_flag_oe ? term_ok_flag_out : 1'b1;
endmodule // sfseq_sys_model

/* sim/tb_top.sv */
// self-checking bench for the supply fault sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] in;
    logic [3:0] exp;
  } sfseq_row_t;
  logic core_clk;
  logic rst_n;
  sfseq_pkg::sfseq_in_t pins;
  sfseq_pkg::sfseq_drv_t drive;
  logic [7:0] target_level;
  logic [7:0] term_limit_level;
  logic smps_out, smps_oe, term_out, term_oe, fault_latched, smps_ok, term_ok;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // in: standby_n pulse_skip_n over under term_in_window; exp: smps_oe term_oe forced_pwm standby_active
  sfseq_row_t rows [7] = '{'{5'h19, 4'h0}, '{5'h11, 4'h2}, '{5'h1D, 4'h8}, '{5'h1B, 4'h8},
                           '{5'h18, 4'h4}, '{5'h09, 4'h5}, '{5'h01, 4'h5}};
  sfseq_top #(.SS_UP_CYC(2550), .SS_DN_CYC(2550), .TERM_RAMP_CYC(510), .UV_PERSIST_CYC(50),
              .TERM_PERSIST_CYC(100)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .pins_in(pins), .drive(drive), .target_level(target_level),
    .term_limit_level(term_limit_level), .smps_ok_flag_out(smps_out), .smps_ok_flag_oe(smps_oe),
    .term_ok_flag_out(term_out), .term_ok_flag_oe(term_oe), .fault_latched(fault_latched));
  sfseq_sys_model partner (
    .smps_ok_flag_out(smps_out), .smps_ok_flag_oe(smps_oe), .term_ok_flag_out(term_out),
    .term_ok_flag_oe(term_oe), .smps_ok(smps_ok), .term_ok(term_ok));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // long enough for six soft-start ramps and three soft-stop ramps
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_target(input logic [7:0] v);
    for (int i = 0; i < 4000 && target_level !== v; i++) tick(1);
  endtask
  task automatic bring_up(input logic p);
    @(posedge core_clk);
    pins <= {3'b111, p, 7'b1100101};
    for (int i = 0; i < 20 && drive.internal_ref_enable !== 1'b1; i++) tick(1);
    check("ref_request", drive.internal_ref_enable, 1'b1);
    tick(4);
    check("smps_oe_ss", smps_oe, 1'b1);
    check("term_oe_ss", term_oe, 1'b1);
    check("skip_ss", drive.force_pulse_skip, 1'b1);
    check("conv_en", drive.converter_enable, 1'b1);
    check("ref_en", drive.ref_enable, 1'b1);
    check("dis_ss", drive.discharge_enable, 1'b0);
    check("latch_ss", fault_latched, 1'b0);
    check("term_lim_ss", term_limit_level, 8'h00);
    wait_target(8'hFF);
    check("target_full", target_level, 8'hFF);
    tick(12);
    check("smps_ok_run", smps_ok, 1'b1);
    check("term_ok_run", term_ok, 1'b1);
    check("term_lim_run", term_limit_level, 8'hFF);
  endtask
  task automatic restart(input logic p);
    @(posedge core_clk);
    pins.shutdown_n <= 1'b0;
    tick(4);
    bring_up(p);
  endtask
  initial begin
    rst_n = 1'b0;
    pins = '0;
    tick(4);
    check("drive_rst", drive, 10'h000);
    check("target_rst", target_level, 8'h00);
    check("smps_oe_rst", smps_oe, 1'b1);
    check("term_oe_rst", term_oe, 1'b1);
    @(posedge core_clk);
    rst_n <= 1'b1;
    pins <= {3'b101, 8'h65};
    tick(6);
    check("conv_lockout", drive.converter_enable, 1'b0);
    bring_up(1'b0);
    $display("test startup done");
    foreach (rows[i]) begin
      @(posedge core_clk);
      pins <= {4'b1110, rows[i].in, 2'b01};
      tick(6);
      check("smps_ok_row", smps_ok, !rows[i].exp[3]);
      check("term_ok_row", term_ok, !rows[i].exp[2]);
      check("fpwm_row", drive.forced_pwm, rows[i].exp[1]);
      check("stby_row", drive.standby_active, rows[i].exp[0]);
      check("latch_row", fault_latched, 1'b0);
      @(posedge core_clk);
      pins <= {4'b1110, 7'h65};
      tick(6);
    end
    $display("test windows done");
    @(posedge core_clk);
    pins.smps_under <= 1'b1;
    tick(60);
    check("latch_uv", fault_latched, 1'b1);
    check("smps_oe_uv", smps_oe, 1'b1);
    check("term_oe_uv", term_oe, 1'b1);
    check("hs_uv", drive.high_side_gate, 1'b0);
    check("ref_uv", drive.ref_enable, 1'b1);
    wait_target(8'h00);
    tick(12);
    check("ls_uv_end", drive.low_side_gate, 1'b0);
    check("dis_unprot", drive.discharge_enable, 1'b0);
    @(posedge core_clk);
    pins.smps_under <= 1'b0;
    restart(1'b1);
    $display("test undervoltage done");
    @(posedge core_clk);
    pins.shutdown_n <= 1'b0;
    tick(4);
    check("smps_oe_sd", smps_oe, 1'b1);
    wait_target(8'h00);
    tick(12);
    check("dis_prot", drive.discharge_enable, 1'b1);
    check("latch_sd", fault_latched, 1'b0);
    bring_up(1'b1);
    @(posedge core_clk);
    {pins.standby_n, pins.term_in_window} <= 2'b00;
    tick(9);
    @(posedge core_clk);
    pins.standby_n <= 1'b1;
    tick(40);
    check("term_lim_ramp", term_limit_level, 8'h13);
    tick(60);
    check("latch_term", fault_latched, 1'b1);
    check("hs_term", drive.high_side_gate, 1'b0);
    @(posedge core_clk);
    pins.term_in_window <= 1'b1;
    wait_target(8'h00);
    restart(1'b1);
    $display("test shutdown done");
    @(posedge core_clk);
    pins.smps_over <= 1'b1;
    tick(4);
    check("ls_ov", drive.low_side_gate, 1'b1);
    check("hs_ov", drive.high_side_gate, 1'b0);
    check("flags_ov", {smps_oe, term_oe}, 2'b11);
    check("rails_ov", {drive.term_enable, drive.ref_enable}, 2'b00);
    check("dis_ov", drive.discharge_enable, 1'b1);
    check("latch_ov", fault_latched, 1'b1);
    @(posedge core_clk);
    pins.smps_over <= 1'b0;
    restart(1'b1);
    $display("test overvoltage done");
    @(posedge core_clk);
    pins.thermal_fault <= 1'b1;
    tick(4);
    check("gates_th", {drive.high_side_gate, drive.low_side_gate}, 2'b00);
    check("flags_th", {smps_oe, term_oe}, 2'b11);
    check("rails_th", {drive.term_enable, drive.ref_enable, drive.discharge_enable}, 3'b000);
    @(posedge core_clk);
    pins.thermal_fault <= 1'b0;
    restart(1'b1);
    $display("test thermal done");
    @(posedge core_clk);
    pins.supply_above_uvlo <= 1'b0;
    tick(4);
    check("gates_uvlo", {drive.high_side_gate, drive.low_side_gate}, 2'b00);
    check("flags_uvlo", {smps_oe, term_oe}, 2'b11);
    check("rails_uvlo", {drive.term_enable, drive.ref_enable}, 2'b00);
    check("dis_uvlo", drive.discharge_enable, 1'b1);
    $display("test lockout done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    tick(4);
    check("drive_rst2", drive, 10'h000);
    check("latch_rst2", fault_latched, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    tick(6);
    check("dis_por", drive.discharge_enable, 1'b1);
    check("ls_por", drive.low_side_gate, 1'b0);
    $display("test reset done");
    conclude();
  end
endmodule // tb_top
